// [verilog/hsc_counter.sv]
// hundredths-seconds counter top: prescaler, two stages, apb, interrupt
`timescale 1ns/1ps
`default_nettype none
module hsc_counter (
  input  wire logic                   core_clk,
  input  wire logic                   nrst,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [hsc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [hsc_pkg::DATA_W-1:0] pwdata,
  output logic      [hsc_pkg::DATA_W-1:0] prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   timeBase512hzTap,
  output logic                        irq
);
  import hsc_pkg::*;

  typedef struct packed {
    hsc_phase_e       phase;
    logic             preadyR;
    logic [DATA_W-1:0] prdataR;
    logic             pslverrR;
    logic             irqR;
    logic             countEnableBit;
    logic [NIB_W-1:0] hundredthsLatch;
    logic [NIB_W-1:0] interruptRequestRegThree;
    logic [NIB_W-1:0] irqMask;
    logic             tapSync1;
    logic             tapSync2;
    logic             tapPrev;
    logic [2:0]       preCount;
    logic [4:0]       preStep;
  } hsc_top_s;

  hsc_top_s state_r;
  hsc_top_s state_nxt;

  hsc_stage_if hundredthsIf ();
  hsc_stage_if tenthsIf ();

  hsc_decade hundredthsStage (
    .core_clk (core_clk),
    .nrst     (nrst),
    .stg      (hundredthsIf)
  );

  hsc_decade tenthsStage (
    .core_clk (core_clk),
    .nrst     (nrst),
    .stg      (tenthsIf)
  );

  logic             busDone;
  logic             busWrite;
  logic             hitHundredths;
  logic             hitTenths;
  logic             hitControl;
  logic             hitStatus;
  logic             hitMask;
  logic             hitAny;
  logic             tapRise;
  logic [2:0]       stepDivisor;
  logic             centiPulse;
  logic             countClear;
  logic             tenthSecondCarryIrq;
  logic [NIB_W-1:0] statusSet;
  logic [NIB_W-1:0] readNibble;

  // decode
  always_comb begin
    hitHundredths = (paddr == ADDR_HUNDREDTHS);
    hitTenths     = (paddr == ADDR_TENTHS);
    hitControl    = (paddr == ADDR_CONTROL);
    hitStatus     = (paddr == ADDR_IRQ_STATUS);
    hitMask       = (paddr == ADDR_IRQ_MASK);
    hitAny        = hitHundredths || hitTenths || hitControl ||
                    hitStatus || hitMask;
  end

  // a write takes effect only at the edge where pready is seen high
  assign busDone  = psel && penable && state_r.preadyR;
  assign busWrite = busDone && pwrite && hitAny;

  // the tap comes from another block; only the second flop is looked at
  assign tapRise = state_r.tapSync2 && !state_r.tapPrev;

  // three long steps spread over the 25 short/long steps give 128 taps
  // per 25 output pulses, i.e. exactly 512:100 on average
  always_comb begin
    // step 24 is also a multiple of the stride but must stay short
    if (((5'(state_r.preStep % 5'(SIX_STRIDE))) == 5'h0) &&
        (state_r.preStep != LAST_STEP)) begin
      stepDivisor = DIV_LONG; // [R11]
    end else begin
      stepDivisor = DIV_SHORT; // [R11]
    end
  end

  assign centiPulse = state_r.countEnableBit && tapRise &&
                      (state_r.preCount == stepDivisor - 3'h1); // [R1]

  // a write of any data to either count register clears both
  assign countClear = busWrite && (hitHundredths || hitTenths); // [R6]

  assign hundredthsIf.advance = centiPulse; // [R2] [R9]
  assign hundredthsIf.clear   = countClear; // [R6]
  assign tenthsIf.advance     = hundredthsIf.carry; // [R2] [R9]
  assign tenthsIf.clear       = countClear; // [R6]

  assign tenthSecondCarryIrq = hundredthsIf.carry;

  always_comb begin
    statusSet = '0;
    statusSet[TENTH_SECOND_BIT] = tenthSecondCarryIrq; // [R3]
  end

  // read mux
  always_comb begin
    readNibble = '0;
    if (hitHundredths) begin
      // pairs with the tenths value read just before
      readNibble = state_r.hundredthsLatch; // [R7] [R8]
    end else if (hitTenths) begin
      readNibble = tenthsIf.count;
    end else if (hitControl) begin
      readNibble[COUNT_ENABLE_BIT] = state_r.countEnableBit;
    end else if (hitStatus) begin
      readNibble = state_r.interruptRequestRegThree;
    end else if (hitMask) begin
      readNibble = state_r.irqMask;
    end
  end

  always_comb begin
    state_nxt = state_r;

    // synchroniser and edge memory
    state_nxt.tapSync1 = timeBase512hzTap;
    state_nxt.tapSync2 = state_r.tapSync1;
    state_nxt.tapPrev  = state_r.tapSync2;

    // prescaler holds its phase while stopped
    if (state_r.countEnableBit && tapRise) begin
      if (state_r.preCount == stepDivisor - 3'h1) begin
        state_nxt.preCount = 3'h0; // [R1]
        if (state_r.preStep == LAST_STEP) begin
          state_nxt.preStep = 5'h0; // [R11]
        end else begin
          state_nxt.preStep = state_r.preStep + 5'h1; // [R11]
        end
      end else begin
        state_nxt.preCount = state_r.preCount + 3'h1; // [R1]
      end
    end

    // bus phase: one wait state, then the answer
    case (state_r.phase)
      HSC_IDLE: begin
        state_nxt.preadyR  = 1'b0;
        state_nxt.pslverrR = 1'b0;
        if (psel && penable) begin
          state_nxt.phase    = HSC_ANSWER;
          state_nxt.preadyR  = 1'b1;
          state_nxt.pslverrR = !hitAny;
          state_nxt.prdataR  = '0;
          if (!pwrite) begin
            state_nxt.prdataR = {{(DATA_W-NIB_W){1'b0}}, readNibble};
          end
        end
      end
      HSC_ANSWER: begin
        state_nxt.phase    = HSC_IDLE;
        state_nxt.preadyR  = 1'b0;
        state_nxt.pslverrR = 1'b0;
      end
      default: begin
        state_nxt.phase   = HSC_IDLE;
        state_nxt.preadyR = 1'b0;
      end
    endcase

    // register writes
    if (busWrite && hitControl) begin
      state_nxt.countEnableBit = pwdata[COUNT_ENABLE_BIT]; // [R4]
    end
    if (busWrite && hitMask) begin
      state_nxt.irqMask = pwdata[NIB_W-1:0] & STATUS_USED;
    end

    // capture hundredths in the edge that samples tenths for prdata,
    // so a carry between the two edges cannot split the pair
    if ((state_r.phase == HSC_IDLE) && psel && penable && !pwrite &&
        hitTenths) begin
      state_nxt.hundredthsLatch = hundredthsIf.count; // [R7]
    end
    if (countClear) begin
      state_nxt.hundredthsLatch = RST_NIBBLE;
    end

    // write one to clear; a new event in the same cycle wins
    if (busWrite && hitStatus) begin
      state_nxt.interruptRequestRegThree =
        state_r.interruptRequestRegThree & ~pwdata[NIB_W-1:0];
    end
    state_nxt.interruptRequestRegThree =
      state_nxt.interruptRequestRegThree | statusSet; // [R3]

    state_nxt.irqR = |(state_nxt.interruptRequestRegThree &
                       state_nxt.irqMask);
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_r                          <= '0;
      state_r.phase                    <= HSC_IDLE;
      state_r.countEnableBit           <= RST_ENABLE; // [R5]
      state_r.hundredthsLatch          <= RST_NIBBLE;
      state_r.interruptRequestRegThree <= RST_NIBBLE;
      state_r.irqMask                  <= RST_MASK;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign prdata  = state_r.prdataR;
  assign pready  = state_r.preadyR;
  assign pslverr = state_r.pslverrR;
  assign irq     = state_r.irqR;
endmodule
`default_nettype wire

// [verilog/hsc_pkg.sv]
// constants, types and register map of the hundredths-seconds counter
// Contract
// R1 - prescale 512 Hz tap to 100 Hz pulse
// R2 - hundredths stage feeds tenths stage by carry
// R3 - hundredths carry sets request flag bit 3
// R4 - control bit 0 starts and stops counting
// R5 - reset leaves the count enable bit clear
// R6 - any count register write zeroes both counters
// R7 - tenths read latches hundredths for next read
// R8 - software reads tenths first, then hundredths
// R9 - chain is prescaler then two decimal stages
// R10 - decimal stage wraps 9 to 0 with carry
// R11 - fixed five/six step pattern, ratio 512:100
`default_nettype none
package hsc_pkg;

  localparam int unsigned ADDR_W        = 12;
  localparam int unsigned DATA_W        = 32;
  localparam int unsigned NIB_W         = 4;

  // register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_HUNDREDTHS = 12'h064;
  localparam logic [ADDR_W-1:0] IDX_TENTHS     = 12'h065;
  localparam logic [ADDR_W-1:0] IDX_CONTROL    = 12'h066;
  localparam logic [ADDR_W-1:0] IDX_IRQ_STATUS = 12'h067;
  localparam logic [ADDR_W-1:0] IDX_IRQ_MASK   = 12'h068;

  localparam logic [ADDR_W-1:0] ADDR_HUNDREDTHS = IDX_HUNDREDTHS << 2;
  localparam logic [ADDR_W-1:0] ADDR_TENTHS     = IDX_TENTHS << 2;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL    = IDX_CONTROL << 2;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = IDX_IRQ_STATUS << 2;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK   = IDX_IRQ_MASK << 2;

  // field positions
  localparam int unsigned COUNT_ENABLE_BIT  = 0;
  localparam int unsigned TENTH_SECOND_BIT  = 3;

  // reset values and used status bits
  localparam logic             RST_ENABLE  = 1'b0;
  localparam logic [NIB_W-1:0] RST_NIBBLE  = 4'h0;
  localparam logic [NIB_W-1:0] RST_MASK    = 4'h0;
  localparam logic [NIB_W-1:0] STATUS_USED = 4'h8;

  // rates, prescaler pattern and decade limit
  localparam int unsigned TAP_RATE_HZ  = 512;
  localparam int unsigned OUT_RATE_HZ  = 100;
  localparam int unsigned PRE_STEPS    = 25;
  localparam int unsigned SIX_STRIDE   = 8;
  localparam logic [4:0]  LAST_STEP    = 5'(PRE_STEPS - 1);
  localparam logic [2:0]  DIV_SHORT    = 3'h5;
  localparam logic [2:0]  DIV_LONG     = 3'h6;
  localparam logic [3:0]  DECADE_LAST  = 4'h9;

  typedef enum logic {
    HSC_IDLE,
    HSC_ANSWER
  } hsc_phase_e;

endpackage
`default_nettype wire

// [verilog/hsc_stage_if.sv]
// handshake bundle between the chain and one decimal stage
`timescale 1ns/1ps
`default_nettype none
interface hsc_stage_if;
  logic       advance;
  logic       clear;
  logic [3:0] count;
  logic       carry;

  modport stage (
    input  advance,
    input  clear,
    output count,
    output carry
  );

  modport chain (
    output advance,
    output clear,
    input  count,
    input  carry
  );
endinterface
`default_nettype wire

// [verilog/hsc_decade.sv]
// one decimal counter stage, 0 to 9 with carry out
`timescale 1ns/1ps
`default_nettype none
module hsc_decade (
  input  wire logic   core_clk,
  input  wire logic   nrst,
  hsc_stage_if.stage  stg
);
  import hsc_pkg::*;

  typedef struct packed {
    logic [NIB_W-1:0] count;
  } hsc_dec_s;

  hsc_dec_s state_r;
  hsc_dec_s state_nxt;

  assign stg.count = state_r.count;
  // carry is combinational so the next stage moves in the same edge
  assign stg.carry = stg.advance && !stg.clear &&
                     (state_r.count == DECADE_LAST); // [R10]

  always_comb begin
    state_nxt = state_r;
    if (stg.clear) begin
      state_nxt.count = RST_NIBBLE;
    end else if (stg.advance) begin
      if (state_r.count == DECADE_LAST) begin
        state_nxt.count = RST_NIBBLE; // [R10]
      end else begin
        state_nxt.count = state_r.count + 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end
endmodule
`default_nettype wire

// [bench/hsc_counter_assertions.sv]
// port-level assertions for the hundredths-seconds counter
`timescale 1ns/1ps
`default_nettype none
module hsc_counter_assertions (
  input wire logic                        core_clk,
  input wire logic                        nrst,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [hsc_pkg::ADDR_W-1:0]  paddr,
  input wire logic [hsc_pkg::DATA_W-1:0]  prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic                        irq
);
  import hsc_pkg::*;
  logic rdDone;
  logic wrDone;
  logic hit;
  assign rdDone = psel && penable && pready && !pwrite;
  assign wrDone = psel && penable && pready && pwrite;
  assign hit = paddr inside {ADDR_HUNDREDTHS, ADDR_TENTHS, ADDR_CONTROL,
                             ADDR_IRQ_STATUS, ADDR_IRQ_MASK};
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  AST_ONE_WAIT: assert property ($rose(penable) && psel |=> pready)
    else $error("answer not one cycle after access");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_ERR_MAP: assert property (pready |-> pslverr == !hit)
    else $error("error flag does not match address map");
  AST_UPPER_ZERO: assert property (pready |-> prdata[31:4] == 28'h0)
    else $error("read data above bit 3 not zero");
  AST_TENTHS_DEC: assert property (
    rdDone && paddr == ADDR_TENTHS |-> prdata[3:0] <= DECADE_LAST)
    else $error("tenths beyond nine");
  AST_HUND_DEC: assert property (
    rdDone && paddr == ADDR_HUNDREDTHS |-> prdata[3:0] <= DECADE_LAST)
    else $error("hundredths latch beyond nine");
  AST_CTRL_BITS: assert property (
    rdDone && paddr == ADDR_CONTROL |-> prdata[3:1] == 3'h0)
    else $error("control spare bits not zero");
  AST_STATUS_BITS: assert property (
    rdDone && paddr == ADDR_IRQ_STATUS |-> prdata[2:0] == 3'h0)
    else $error("status spare bits not zero");
  AST_IRQ_FALL: assert property (
    $fell(irq) |-> $past(wrDone))
    else $error("interrupt dropped without a write");
  AST_RST_QUIET: assert property (disable iff (1'b0)
    !nrst |=> !irq && !pready)
    else $error("outputs active after reset");
endmodule
bind hsc_counter hsc_counter_assertions u_hsc_counter_assertions (
  .core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .irq(irq));
`default_nettype wire

// [bench/tb_top.sv]
// self-checking bench of the hundredths-seconds counter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import hsc_pkg::*;
  logic              core_clk;
  logic              nrst;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              tap;
  logic              irq;
  int                nMismatch;
  int                numChecks;
  int                cyc;

  hsc_counter u_hsc_counter (.core_clk(core_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timeBase512hzTap(tap), .irq(irq));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic endOfTest();
    if (nMismatch == 0 && numChecks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      nMismatch++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask

  // request held until ready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    chk({31'h0, e}, 32'h0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk({31'h0, e}, 32'h0);
  endtask

  // tenths first so the hundredths read returns the latched value
  task automatic pair(input logic [3:0] t, input logic [3:0] h);
    rd(ADDR_TENTHS, {28'h0, t});
    rd(ADDR_HUNDREDTHS, {28'h0, h});
  endtask

  // edges are spaced well past the two-flop synchroniser
  task automatic taps(input int n);
    repeat (n) begin
      tap <= 1'b1;
      repeat (4) @(posedge core_clk);
      tap <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
    repeat (4) @(posedge core_clk);
  endtask

  task automatic tReset();
    rd(ADDR_CONTROL, 32'h0);
    rd(ADDR_IRQ_STATUS, 32'h0);
    taps(12);
    pair(4'h0, 4'h0);
  endtask

  task automatic tUnmapped();
    logic [31:0] r;
    logic        e;
    apb(1'b1, 12'h000, 32'hf, r, e);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, 12'h000, 32'h0, r, e);
    chk({r[31:1], e}, 32'h1);
    chk(r, 32'h0);
  endtask

  // 128 tap edges are 25 advances at 512:100, so two carries
  task automatic tCount();
    wr(ADDR_CONTROL, 32'h1);
    taps(128);
    pair(4'h2, 4'h5);
    rd(ADDR_IRQ_STATUS, 32'h8);
    chk({31'h0, irq}, 32'h0);
    wr(ADDR_IRQ_MASK, 32'h8);
    @(posedge core_clk);
    chk({31'h0, irq}, 32'h1);
    wr(ADDR_IRQ_STATUS, 32'h8);
    @(posedge core_clk);
    chk({31'h0, irq}, 32'h0);
  endtask

  task automatic tStopLatch();
    wr(ADDR_CONTROL, 32'h0);
    taps(40);
    pair(4'h2, 4'h5);
    wr(ADDR_CONTROL, 32'h1);
    rd(ADDR_TENTHS, 32'h2);
    taps(10);
    rd(ADDR_HUNDREDTHS, 32'h5);
  endtask

  task automatic tClear();
    logic [11:0] adr[2];
    adr = '{ADDR_HUNDREDTHS, ADDR_TENTHS};
    foreach (adr[i]) begin
      taps(30);
      wr(adr[i], 32'h5 + 32'(i * 10));
      pair(4'h0, 4'h0);
    end
  endtask

  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    tap = 1'b0;
    nMismatch = 0;
    numChecks = 0;
    cyc = 0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    tReset();
    tUnmapped();
    tCount();
    tStopLatch();
    tClear();
    endOfTest();
  end

  // the scenarios need about 2100 cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      nMismatch++;
      endOfTest();
    end
  end
endmodule
`default_nettype wire
